/* core/loop_ctl_pkg.sv */
package loop_ctl_pkg;
  // APB byte address of the control register (register index 6, one word each)
  localparam logic [7:0] CTL_INDEX       = 8'h06;
  localparam logic [7:0] CTL_ADDR        = 8'h18;
  // Mode and status register
  localparam logic [7:0] MODE_ADDR       = 8'h1C;
  localparam logic [7:0] CTL_RESET       = 8'hC1;
  localparam int         MON_EN_BIT      = 7;
  localparam int         LOOP_PWR_BIT    = 6;
  localparam int         FM_HI_BIT       = 5;
  localparam int         FM_LO_BIT       = 4;
  localparam int         FAST_WAKE_BIT   = 3;
  localparam int         TIMER_RUN_BIT   = 2;
  localparam int         WDOG_RUN_BIT    = 1;
  localparam int         SELF_CLK_EN_BIT = 0;
  localparam logic [1:0] FM_OFF          = 2'h0;
  localparam logic [1:0] FM_1PCT         = 2'h1;
  localparam logic [1:0] FM_2PCT         = 2'h2;
  localparam logic [1:0] FM_4PCT         = 2'h3;
  localparam logic [3:0] MOD_DIV_LAST    = 4'hF;
endpackage

/* core/mod_rate_div.sv */
`timescale 1ns/1ps
`default_nettype none
module mod_rate_div
  import loop_ctl_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic ref_tick_i,
  output var  logic mod_tick_o
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } div_state_type;
  div_state_type s_r, s_nxt;
  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (ref_tick_i) begin
      s_nxt.cnt = s_r.cnt + 4'h1;
      if (s_r.cnt == MOD_DIV_LAST) begin
        s_nxt.tick = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign mod_tick_o = s_r.tick;
endmodule
`default_nettype wire

/* core/loop_monitor_ctl.sv */
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module loop_monitor_ctl
  import loop_ctl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output var  logic [31:0] prdata_o,
  output var  logic        pready_o,
  output var  logic        pslverr_o,
  input  wire logic        special_mode_i,
  input  wire logic        loop_sel_req_i,
  input  wire logic        loop_lock_i,
  input  wire logic        pseudo_stop_select_i,
  input  wire logic        stop_req_i,
  input  wire logic        wait_req_i,
  input  wire logic        loop_stops_in_wait_i,
  input  wire logic        osc_fail_i,
  input  wire logic        quality_ok_i,
  input  wire logic        ref_tick_i,
  output var  logic        monitor_on_o,
  output var  logic        loop_on_o,
  output var  logic [1:0]  mod_amp_o,
  output var  logic        mod_tick_o,
  output var  logic        osc_on_o,
  output var  logic        quality_check_o,
  output var  logic        monitor_reset_o,
  output var  logic        self_clock_active_o,
  output var  logic        self_clock_change_o,
  output var  logic        loop_clock_select_o,
  output var  logic        timer_run_o,
  output var  logic        watchdog_run_o
);
  typedef enum logic [1:0] {RUN, FULL_STOP, FAST_SELF, CHECKING} phase_type;

  typedef struct packed {
    logic [7:0]  ctl;
    logic        once_used;
    logic        self_clk;
    logic        loop_sel;
    phase_type   phase;
    logic        mon_rst;
    logic        change;
    logic        mon_on;
    logic        loop_on;
    logic        osc_on;
    logic        timer_run;
    logic        wdog_run;
    logic        mod_tick;
    logic        qchk;
    logic        ready;
    logic [31:0] rdata;
  } ctl_state_type;

  ctl_state_type s_r, s_nxt;
  logic          wr, rd, acc, mod_tick;
  logic [7:0]    wd;

  // A write lands at the edge where the master sees pready high, so the
  // register and the master agree on the edge that completes the transfer
  always_comb begin
    acc = psel_i && penable_i && !s_r.ready;
    wr  = psel_i && penable_i && s_r.ready && pwrite_i && pstrb_i[0] && (paddr_i == CTL_ADDR);
    rd  = acc && !pwrite_i;
    wd  = pwdata_i[7:0];
  end

  always_comb begin
    s_nxt         = s_r;
    s_nxt.ready   = acc;
    s_nxt.mon_rst = 1'b0;
    s_nxt.change  = 1'b0;
    if (wr) begin
      if (!s_r.self_clk) s_nxt.ctl[MON_EN_BIT] = wd[MON_EN_BIT];
      if (!s_r.loop_sel) s_nxt.ctl[LOOP_PWR_BIT] = wd[LOOP_PWR_BIT];
      if (!s_r.loop_sel) s_nxt.ctl[FM_HI_BIT:FM_LO_BIT] = wd[FM_HI_BIT:FM_LO_BIT];
      s_nxt.ctl[FAST_WAKE_BIT] = wd[FAST_WAKE_BIT];
      s_nxt.ctl[TIMER_RUN_BIT] = wd[TIMER_RUN_BIT];
      s_nxt.ctl[WDOG_RUN_BIT] = wd[WDOG_RUN_BIT];
      if (special_mode_i || !s_r.once_used) begin
        if (!(s_r.self_clk && !wd[SELF_CLK_EN_BIT])) s_nxt.ctl[SELF_CLK_EN_BIT] = wd[SELF_CLK_EN_BIT];
        s_nxt.once_used = 1'b1;
      end
    end

    // Loop select is set by request only when locked; dropping the request clears it
    if (loop_sel_req_i && loop_lock_i) s_nxt.loop_sel = 1'b1;
    else if (!loop_sel_req_i) s_nxt.loop_sel = 1'b0;
    if (s_r.self_clk || stop_req_i || (wait_req_i && loop_stops_in_wait_i)) s_nxt.loop_sel = 1'b0;

    case (s_r.phase)
      RUN: begin
        if (stop_req_i && !pseudo_stop_select_i) s_nxt.phase = FULL_STOP;
      end
      FULL_STOP: begin
        if (!stop_req_i) begin
          // no fast wake without self-clock enable
          if (s_r.ctl[FAST_WAKE_BIT] && s_r.ctl[SELF_CLK_EN_BIT]) begin
            s_nxt.phase    = FAST_SELF;
            s_nxt.self_clk = 1'b1;
          end else begin
            s_nxt.phase = RUN;
          end
        end
      end
      FAST_SELF: begin
        if (!s_r.ctl[FAST_WAKE_BIT]) s_nxt.phase = CHECKING;
      end
      default: begin
        if (quality_ok_i) begin
          s_nxt.phase    = RUN;
          s_nxt.self_clk = 1'b0;
          s_nxt.change   = 1'b1;
        end
      end
    endcase
    // Registered so the check output comes from a flop, aligned with the phase
    s_nxt.qchk = (s_nxt.phase == CHECKING);

    s_nxt.mon_on = s_r.ctl[MON_EN_BIT] && (s_r.phase != FULL_STOP) && (s_r.phase != FAST_SELF);
    if (s_r.mon_on && osc_fail_i && !s_r.self_clk) begin
      if (s_r.ctl[SELF_CLK_EN_BIT]) begin
        s_nxt.self_clk = 1'b1;
        s_nxt.change   = 1'b1;
      end else begin
        s_nxt.mon_rst = 1'b1;
      end
    end

    s_nxt.loop_on = s_r.ctl[LOOP_PWR_BIT] || s_r.self_clk;
    s_nxt.osc_on = (s_r.phase == RUN && !(stop_req_i && !pseudo_stop_select_i)) || s_r.phase == CHECKING;
    s_nxt.timer_run = !(stop_req_i && pseudo_stop_select_i) || s_r.ctl[TIMER_RUN_BIT];
    s_nxt.wdog_run = !(stop_req_i && pseudo_stop_select_i) || s_r.ctl[WDOG_RUN_BIT];
    // modulation tick gated by amplitude; one cycle later than the divider
    s_nxt.mod_tick = mod_tick && (s_r.ctl[FM_HI_BIT:FM_LO_BIT] != FM_OFF);

    s_nxt.rdata = '0;
    if (rd) begin
      if (paddr_i == CTL_ADDR) begin
        s_nxt.rdata[7:0] = s_r.ctl;
      end else if (paddr_i == MODE_ADDR) begin
        s_nxt.rdata[2:0] = {s_r.loop_sel, s_r.once_used, s_r.self_clk};
      end else begin
        s_nxt.rdata = '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_r       <= '0;
      s_r.ctl   <= CTL_RESET;
      s_r.phase <= RUN;
    end else begin
      s_r <= s_nxt;
    end
  end

  mod_rate_div u_div (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .ref_tick_i (ref_tick_i),
    .mod_tick_o (mod_tick)
  );

  always_comb begin
    prdata_o            = s_r.rdata;
    pready_o            = s_r.ready;
    pslverr_o           = 1'b0;
    monitor_on_o        = s_r.mon_on;
    loop_on_o           = s_r.loop_on;
    mod_amp_o           = s_r.ctl[FM_HI_BIT:FM_LO_BIT];
    mod_tick_o          = s_r.mod_tick;
    osc_on_o            = s_r.osc_on;
    quality_check_o     = s_r.qchk;
    monitor_reset_o     = s_r.mon_rst;
    self_clock_active_o = s_r.self_clk;
    self_clock_change_o = s_r.change;
    loop_clock_select_o = s_r.loop_sel;
    timer_run_o         = s_r.timer_run;
    watchdog_run_o      = s_r.wdog_run;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Fast wake-up is a chain: leave full stop, sit in self-clock, then check
  sequence wake_cond_s;
    s_r.phase == FULL_STOP && !stop_req_i && s_r.ctl[FAST_WAKE_BIT] && s_r.ctl[SELF_CLK_EN_BIT];
  endsequence
  sequence wake_done_s;
    self_clock_active_o && !self_clock_change_o && !osc_on_o;
  endsequence
  sequence check_start_s;
    quality_check_o ##1 osc_on_o;
  endsequence

  monitor_lock_a: assert property ($past(s_r.self_clk) && $past(wr) |-> s_r.ctl[MON_EN_BIT] == $past(s_r.ctl[MON_EN_BIT]))
    else $error("monitor enable changed in self-clock");
  full_stop_mon_a: assert property (s_r.phase == FULL_STOP |=> !monitor_on_o)
    else $error("monitor on in full stop");
  loop_forced_a: assert property (s_r.self_clk |=> loop_on_o)
    else $error("loop off in self-clock");
  pwr_lock_a: assert property ($past(s_r.loop_sel) && $past(wr) |-> s_r.ctl[LOOP_PWR_BIT] == $past(s_r.ctl[LOOP_PWR_BIT]))
    else $error("loop power changed while selected");
  fm_lock_a: assert property ($past(s_r.loop_sel) && $past(wr) |-> mod_amp_o == $past(mod_amp_o))
    else $error("modulation changed while selected");
  fast_wake_a: assert property (s_r.phase == FAST_SELF |-> s_r.self_clk && !osc_on_o && !self_clock_change_o)
    else $error("fast wake state wrong");
  self_clock_mode_enable_hold_a: assert property (s_r.self_clk && s_r.ctl[SELF_CLK_EN_BIT] |=> s_r.ctl[SELF_CLK_EN_BIT])
    else $error("self-clock enable cleared in self-clock");
  fail_reset_a: assert property (s_r.mon_on && osc_fail_i && !s_r.self_clk && !s_r.ctl[SELF_CLK_EN_BIT] |=> monitor_reset_o)
    else $error("no monitor reset on failure");
  sel_clear_a: assert property (s_r.self_clk |=> !loop_clock_select_o)
    else $error("loop select not cleared");

  fast_entry_a: assert property (wake_cond_s |=> wake_done_s)
    else $error("fast wake-up entry wrong");
  wake_mon_off_a: assert property (s_r.phase == FAST_SELF |=> !monitor_on_o)
    else $error("monitor on after fast wake-up");
  check_start_a: assert property (s_r.phase == FAST_SELF && !s_r.ctl[FAST_WAKE_BIT] |=> check_start_s)
    else $error("quality check not started");
  check_pass_a: assert property (s_r.phase == CHECKING && quality_ok_i |=> !self_clock_active_o && self_clock_change_o)
    else $error("no return to oscillator after check");
  fail_self_a: assert property (s_r.mon_on && osc_fail_i && !s_r.self_clk && s_r.ctl[SELF_CLK_EN_BIT] |=> self_clock_active_o)
    else $error("no self-clock entry on failure");
  stop_sel_clr_a: assert property (stop_req_i |=> !loop_clock_select_o)
    else $error("loop select kept in stop");
  timer_freeze_a: assert property (stop_req_i && pseudo_stop_select_i && !s_r.ctl[TIMER_RUN_BIT] |=> !timer_run_o)
    else $error("timer runs in pseudo stop");
  wdog_freeze_a: assert property (stop_req_i && pseudo_stop_select_i && !s_r.ctl[WDOG_RUN_BIT] |=> !watchdog_run_o)
    else $error("watchdog runs in pseudo stop");
  once_lock_a: assert property ($past(!special_mode_i && s_r.once_used && wr) |-> s_r.ctl[SELF_CLK_EN_BIT] == $past(s_r.ctl[SELF_CLK_EN_BIT]))
    else $error("self-clock enable written twice");
  sticky_once_a: assert property (s_r.once_used |=> s_r.once_used)
    else $error("write-once flag cleared");
endmodule
`default_nettype wire

/* tb/tb_loop_monitor_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_loop_monitor_ctl;
  import loop_ctl_pkg::*;
  logic        clk_i, reset_i, psel_i, penable_i, pwrite_i, special_mode_i, loop_sel_req_i, loop_lock_i;
  logic        pseudo_stop_select_i, stop_req_i, wait_req_i, loop_stops_in_wait_i, osc_fail_i, quality_ok_i;
  logic        ref_tick_i, pready_o, pslverr_o, monitor_on_o, loop_on_o, mod_tick_o, osc_on_o, quality_check_o;
  logic        monitor_reset_o, self_clock_active_o, self_clock_change_o, loop_clock_select_o;
  logic        timer_run_o, watchdog_run_o;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic [1:0]  mod_amp_o;
  int          fail_count, check_count, chg_n, mrst_n, tick_n, c;

  loop_monitor_ctl loop_monitor_ctl_i (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'h1),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .special_mode_i(special_mode_i),
    .loop_sel_req_i(loop_sel_req_i), .loop_lock_i(loop_lock_i), .pseudo_stop_select_i(pseudo_stop_select_i),
    .stop_req_i(stop_req_i), .wait_req_i(wait_req_i), .loop_stops_in_wait_i(loop_stops_in_wait_i),
    .osc_fail_i(osc_fail_i), .quality_ok_i(quality_ok_i), .ref_tick_i(ref_tick_i),
    .monitor_on_o(monitor_on_o), .loop_on_o(loop_on_o), .mod_amp_o(mod_amp_o), .mod_tick_o(mod_tick_o),
    .osc_on_o(osc_on_o), .quality_check_o(quality_check_o), .monitor_reset_o(monitor_reset_o),
    .self_clock_active_o(self_clock_active_o), .self_clock_change_o(self_clock_change_o),
    .loop_clock_select_o(loop_clock_select_o), .timer_run_o(timer_run_o), .watchdog_run_o(watchdog_run_o));

  always #12.5 clk_i = ~clk_i;

  // Pulse outputs are counted so that a check can span any window
  always @(posedge clk_i) begin
    if (self_clock_change_o === 1'b1) chg_n++;
    if (monitor_reset_o === 1'b1) mrst_n++;
    if (mod_tick_o === 1'b1) tick_n++;
  end

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One APB transfer; the extra edge after release keeps psel from being driven twice in one step
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (k >= 20) chk(32'h0000_0000, 32'h0000_0001);
    q = prdata_o;
    chk(pslverr_o, 32'h0000_0000);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask

  task automatic rst(logic special);
    reset_i <= 1'b1;
    step(10);
    reset_i        <= 1'b0;
    special_mode_i <= special;
    step(2);
  endtask

  task automatic conclude();
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #(25 * 5000);
    fail_count++;
    conclude();
  end

  initial begin
    {clk_i, psel_i, penable_i, pwrite_i, loop_sel_req_i, loop_lock_i, pseudo_stop_select_i} = '0;
    {stop_req_i, wait_req_i, loop_stops_in_wait_i, osc_fail_i, quality_ok_i, ref_tick_i} = '0;
    {paddr_i, pwdata_i, fail_count, check_count, chg_n, mrst_n, tick_n} = '0;
    reset_i = 1'b1;
    special_mode_i = 1'b1;
    rst(1'b1);
    rd(CTL_ADDR, 32'h0000_00C1);
    chk(monitor_on_o & loop_on_o, 32'h0000_0001);
    rd(8'h40, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(CTL_ADDR, {24'h0000_00, 2'b11, 2'(i), 4'h1});
      step(2);
      chk(mod_amp_o, 32'(i));
    end
    c = tick_n;
    repeat (32) begin
      ref_tick_i <= 1'b1;
      step(1);
      ref_tick_i <= 1'b0;
      step(1);
    end
    step(3);
    chk(32'(tick_n - c), 32'h0000_0002);
    loop_lock_i    <= 1'b1;
    loop_sel_req_i <= 1'b1;
    step(3);
    chk(loop_clock_select_o, 32'h0000_0001);
    wr(CTL_ADDR, 32'h0000_0081);
    rd(CTL_ADDR, 32'h0000_00F1);
    loop_sel_req_i <= 1'b0;
    stop_req_i     <= 1'b1;
    step(3);
    chk(loop_clock_select_o, 32'h0000_0000);
    chk({monitor_on_o, osc_on_o}, 32'h0000_0000);
    stop_req_i <= 1'b0;
    step(3);
    {stop_req_i, pseudo_stop_select_i} <= 2'b11;
    step(3);
    chk({osc_on_o, timer_run_o, watchdog_run_o}, 32'h0000_0004);
    wr(CTL_ADDR, 32'h0000_00F7);
    step(2);
    chk({timer_run_o, watchdog_run_o}, 32'h0000_0003);
    {stop_req_i, pseudo_stop_select_i, loop_sel_req_i} <= 3'b001;
    step(3);
    {loop_sel_req_i, wait_req_i, loop_stops_in_wait_i} <= 3'b111;
    step(3);
    chk(loop_clock_select_o, 32'h0000_0000);
    {loop_sel_req_i, wait_req_i} <= 2'b00;
    wr(CTL_ADDR, 32'h0000_0081);
    step(2);
    chk(loop_on_o, 32'h0000_0000);
    osc_fail_i <= 1'b1;
    step(3);
    osc_fail_i <= 1'b0;
    chk({self_clock_active_o, loop_on_o}, 32'h0000_0003);
    wr(CTL_ADDR, 32'h0000_0000);
    rd(CTL_ADDR, 32'h0000_0081);
    wr(MODE_ADDR, 32'h0000_0000);
    rd(MODE_ADDR, 32'h0000_0003);
    rst(1'b0);
    wr(CTL_ADDR, 32'h0000_00C0);
    wr(CTL_ADDR, 32'h0000_00C1);
    rd(CTL_ADDR, 32'h0000_00C0);
    rd(MODE_ADDR, 32'h0000_0002);
    c = mrst_n;
    osc_fail_i <= 1'b1;
    step(4);
    osc_fail_i <= 1'b0;
    chk({31'(mrst_n > c), self_clock_active_o}, 32'h0000_0002);
    rst(1'b1);
    wr(CTL_ADDR, 32'h0000_00C9);
    c = chg_n;
    stop_req_i <= 1'b1;
    step(3);
    stop_req_i <= 1'b0;
    step(3);
    chk({self_clock_active_o, osc_on_o, monitor_on_o}, 32'h0000_0004);
    chk(32'(chg_n - c), 32'h0000_0000);
    wr(CTL_ADDR, 32'h0000_00C1);
    step(2);
    chk({quality_check_o, osc_on_o}, 32'h0000_0003);
    quality_ok_i <= 1'b1;
    step(1);
    quality_ok_i <= 1'b0;
    step(3);
    chk({self_clock_active_o, 31'(chg_n - c)}, 32'h0000_0001);
    conclude();
  end
endmodule
`default_nettype wire
